// ---- rtl/wipc_pkg.sv ----
// shared constants and types of the wake and interrupt pin controller
package wipc_pkg;

   // ---------------------------------------------------------------
   // clock and time figures
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 8;          // 125 mhz system clock
   localparam int CLK_FREQ_KHZ  = 125000;     // same rate in khz
   localparam int CLR_DELAY_NS  = 1000;       // release delay after select falls
   localparam int CLR_CYC       = (CLR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PULSE_US      = 100;        // interrupt pulse length
   localparam int PULSE_CYC     = (PULSE_US * 1000) / CLK_PERIOD_NS;
   localparam int SLOW_OSC_KHZ  = 192;        // always-on slow oscillator
   localparam int FAST_OSC_KHZ  = 4000;       // active-state oscillator
   localparam int SLOW_DIV      = CLK_FREQ_KHZ / SLOW_OSC_KHZ;
   localparam int BASE_DIV      = 192;        // slow ticks per base tick

   // ---------------------------------------------------------------
   // widths and reset values
   // ---------------------------------------------------------------
   localparam int NCH           = 33;         // 12 programmable + 21 ground inputs
   localparam int TMR_W         = 16;         // timer period width in base ticks
   localparam int CLR_W         = 8;          // release counter width
   localparam int PULSE_W       = 16;         // pulse counter width
   localparam logic RST_PULSE_MODE = 1'b0;    // held-low style after reset

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      WIPC_START  = 4'b0001,                  // start-up, line held low
      WIPC_ACTIVE = 4'b0010,                  // normal state
      WIPC_LOWPWR = 4'b0100,                  // low_power_state
      WIPC_CHECK  = 4'b1000                   // io supply check after an edge
   } wipc_state_e;

   typedef struct packed {
      logic irq_line_level;                   // line level at select fall
      logic irq_flag_bit;                     // this device raised it
   } wipc_status_s;

   typedef struct packed {
      logic [TMR_W-1:0] poll_period;          // polling period, base ticks
      logic [TMR_W-1:0] irq_period;           // periodic interrupt, base ticks
   } wipc_timer_cfg_s;

endpackage

// ---- rtl/wipc_sync.sv ----
// two flip-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ps

module wipc_sync #(
   parameter int W = 1                        // number of levels
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_reg;                    // first stage, read by second only
   logic [W-1:0] meta_next;
   logic [W-1:0] q_reg;                       // second stage
   logic [W-1:0] q_next;

   // next values
   always_comb begin
      meta_next = d;
      q_next    = meta_reg;
   end

   // registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         meta_reg <= '1;                      // pins idle high
         q_reg    <= '1;
      end else begin
         meta_reg <= meta_next;
         q_reg    <= q_next;
      end
   end

   assign q = q_reg;

endmodule // wipc_sync

// ---- rtl/wipc_base_timer.sv ----
// shared low-power base tick derived from the slow oscillator rate
`timescale 1ns/1ps

module wipc_base_timer
   import wipc_pkg::*;
#(
   parameter int SDIV = wipc_pkg::SLOW_DIV,   // clk cycles per slow tick
   parameter int BDIV = wipc_pkg::BASE_DIV    // slow ticks per base tick
) (
   input  wire logic clk,
   input  wire logic resetn,
   output logic      base_tick               // one-cycle pulse
);

   logic [15:0] slow_cnt_reg;                 // slow oscillator emulation
   logic [15:0] slow_cnt_next;
   logic [15:0] base_cnt_reg;                 // base divider
   logic [15:0] base_cnt_next;
   logic        tick_reg;
   logic        tick_next;

   // next values of both dividers
   always_comb begin
      slow_cnt_next = slow_cnt_reg + 16'h0001;
      base_cnt_next = base_cnt_reg;
      tick_next     = 1'b0;
      if (slow_cnt_reg == 16'(SDIV - 1)) begin
         slow_cnt_next = 16'h0000;
         base_cnt_next = base_cnt_reg + 16'h0001;
         if (base_cnt_reg == 16'(BDIV - 1)) begin
            base_cnt_next = 16'h0000;
            tick_next     = 1'b1;
         end
      end
   end

   // registers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         slow_cnt_reg <= 16'h0000;
         base_cnt_reg <= 16'h0000;
         tick_reg     <= 1'b0;
      end else begin
         slow_cnt_reg <= slow_cnt_next;
         base_cnt_reg <= base_cnt_next;
         tick_reg     <= tick_next;
      end
   end

   assign base_tick = tick_reg;

endmodule // wipc_base_timer

// ---- rtl/wipc_ctrl.sv ----
// wake pin, shared interrupt line and low-power state control
`timescale 1ns/1ps

// Behaviour
// - slow timing always; fast oscillator only active
// - all low-power timers share one base tick
// - interrupt timer wins, polling skipped that tick
// - thermal cells ORed; limit wetting until hysteresis
// - thermal warning flag reported separately
// - wake pin low active, released low power
// - wake falling edge with supply wakes device
// - supply-check bit gates wake edge without supply
// - valid wake leaves low power, wake low
// - interrupt line only pulled low, open drain
// - enabled channel change asserts interrupt line
// - line level and flag captured at select fall
// - release line and flag 1 us later
// - change during select low keeps line asserted
// - interrupt line falling edge wakes from low power
// - held-low or pulsed style; held-low after reset
// - request command gives one 100 us pulse
// - change, timer, wake, thermal fault assert line; fault_event only when active
// - line held low through start-up until ready
// - comparator polarity per ground or battery input
// - muxed input not polled, no wake events
// - edge then supply check; low supply sleeps
// - interrupt timer expiry interrupts and wakes
module wipc_ctrl
   import wipc_pkg::*;
#(
   parameter int                 N         = wipc_pkg::NCH,
   parameter logic [PULSE_W-1:0] PULSE_LEN = PULSE_W'(wipc_pkg::PULSE_CYC)
) (
   input  wire logic                      clk,
   input  wire logic                      resetn,
   input  wire logic                      wake_pin_i,
   output logic                           wake_pin_o,
   output logic                           wake_pin_oe,
   input  wire logic                      irq_pin_i,
   output logic                           irq_pin_o,
   output logic                           irq_pin_oe,
   input  wire logic                      cs_n_i,
   input  wire logic                      io_supply,
   input  wire logic [N-1:0]              cmp_above,
   input  wire logic [N-1:0]              battery_switch_config,
   input  wire logic [N-1:0]              irq_enable,
   input  wire logic [N-1:0]              wake_enable,
   input  wire logic                      analog_output_mux_sel_valid,
   input  wire logic [5:0]                analog_output_mux_sel,
   input  wire logic                      supply_check_cfg,
   input  wire logic                      irq_pulse_mode,
   input  wire logic                      irq_request,
   input  wire logic                      enter_low_power,
   input  wire logic                      ready,
   input  wire logic                      fault_event,
   input  wire logic [3:0]                thermal_limit_cells,
   input  wire logic                      thermal_below_hys,
   input  wire logic                      thermal_warn_in,
   input  wire wipc_pkg::wipc_timer_cfg_s timer_cfg,
   output wipc_pkg::wipc_status_s         status,
   output logic [N-1:0]                   switch_closed,
   output logic                           low_power_state,
   output logic                           fast_osc_en,
   output logic                           poll_strobe,
   output logic                           wake_event,
   output logic                           thermal_limit_fault,
   output logic                           wetting_limit,
   output logic                           thermal_warning_flag
);

   // ---------------------------------------------------------------
   // synchronisers and edges
   // ---------------------------------------------------------------
   logic [N+3:0]  sync_q;                     // synced pins
   logic          wake_s;                     // synced wake pin
   logic          irq_s;                      // synced interrupt line
   logic          cs_n_s;                     // synced chip select
   logic          sup_s;                      // synced io supply
   logic [N-1:0]  cmp_s;                      // synced comparators
   logic [2:0]    prev_reg;                   // previous wake, irq, cs samples
   logic [2:0]    prev_next;
   logic          wake_fall;
   logic          irq_fall;
   logic          cs_fall;
   logic          base_tick;                  // shared low-power tick

   wipc_sync #(.W(N + 4)) u_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      ({cmp_above, io_supply, cs_n_i, irq_pin_i, wake_pin_i}),
      .q      (sync_q)
   );

   wipc_base_timer u_base (
      .clk       (clk),
      .resetn    (resetn),
      .base_tick (base_tick)
   );

   assign wake_s = sync_q[0];
   assign irq_s  = sync_q[1];
   assign cs_n_s = sync_q[2];
   assign sup_s  = sync_q[3];
   assign cmp_s  = sync_q[N+3:4];

   // edges come from synced samples only
   always_comb begin
      prev_next = {cs_n_s, irq_s, wake_s};
      wake_fall = prev_reg[0] & ~wake_s;
      irq_fall  = prev_reg[1] & ~irq_s;
      cs_fall   = prev_reg[2] & ~cs_n_s;
   end

   // ---------------------------------------------------------------
   // switch interpretation and change detection
   // ---------------------------------------------------------------
   logic [N-1:0]  closed;                     // closed per polarity
   logic [N-1:0]  ref_reg;                    // reference state
   logic [N-1:0]  ref_next;
   logic [N-1:0]  mux_mask;                   // input routed to analog_output_mux
   logic          act_change;                 // enabled change while active
   logic          poll_change;                // wake change found by a poll

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_ch
         // battery inputs close above threshold, ground inputs below
         assign closed[gi]   = battery_switch_config[gi] ? cmp_s[gi] : ~cmp_s[gi];
         assign mux_mask[gi] = analog_output_mux_sel_valid && (analog_output_mux_sel == 6'(gi));
      end
   endgenerate

   // ---------------------------------------------------------------
   // state machine and low-power timers
   // ---------------------------------------------------------------
   wipc_state_e       st_reg;
   wipc_state_e       st_next;
   logic [TMR_W-1:0]  poll_cnt_reg;           // base ticks since last poll
   logic [TMR_W-1:0]  poll_cnt_next;
   logic [TMR_W-1:0]  itmr_cnt_reg;           // base ticks toward periodic interrupt
   logic [TMR_W-1:0]  itmr_cnt_next;
   logic              bypass_reg;             // edge may skip supply check
   logic              bypass_next;
   logic              poll_due;
   logic              itmr_due;
   logic              wake_ev;                // valid wake this cycle
   logic              timer_ev;               // periodic expiry this cycle
   logic              poll_go;

   always_comb begin
      poll_due    = (poll_cnt_reg + TMR_W'(1)) >= timer_cfg.poll_period;
      itmr_due    = (itmr_cnt_reg + TMR_W'(1)) >= timer_cfg.irq_period;
      st_next     = st_reg;
      poll_cnt_next = poll_cnt_reg;
      itmr_cnt_next = itmr_cnt_reg;
      bypass_next = bypass_reg;
      wake_ev     = 1'b0;
      timer_ev    = 1'b0;
      poll_go     = 1'b0;
      poll_change = 1'b0;
      ref_next    = ref_reg;
      act_change  = 1'b0;
      unique case (st_reg)
         WIPC_START: begin
            // wait for start-up to finish
            if (ready) begin
               st_next  = WIPC_ACTIVE;
               ref_next = closed;
            end
         end
         WIPC_ACTIVE: begin
            // follow the switches, flag enabled changes
            act_change = |((closed ^ ref_reg) & irq_enable);
            ref_next   = closed;
            poll_cnt_next = '0;
            itmr_cnt_next = '0;
            if (enter_low_power) begin
               st_next = WIPC_LOWPWR;
            end
         end
         WIPC_LOWPWR: begin
            if (base_tick) begin
               poll_cnt_next = poll_due ? '0 : poll_cnt_reg + TMR_W'(1);
               itmr_cnt_next = itmr_due ? '0 : itmr_cnt_reg + TMR_W'(1);
            end
            if (base_tick && itmr_due) begin
               // interrupt timer wins a shared tick
               timer_ev = 1'b1;
               wake_ev  = 1'b1;
               st_next  = WIPC_ACTIVE;
            end else if (base_tick && poll_due && |wake_enable) begin
               poll_go     = 1'b1;
               poll_change = |((closed ^ ref_reg) & wake_enable & ~mux_mask);
               if (poll_change) begin
                  wake_ev = 1'b1;
                  st_next = WIPC_ACTIVE;
               end
            end else if (wake_fall && wake_s == 1'b0 && prev_reg[0]) begin
               // wake edge: supply high or check bit set lets it through
               bypass_next = supply_check_cfg;
               st_next     = WIPC_CHECK;
            end else if (irq_fall || cs_fall) begin
               bypass_next = 1'b0;
               st_next     = WIPC_CHECK;
            end
         end
         WIPC_CHECK: begin
            // confirm io supply before reporting a wake
            if (sup_s || bypass_reg) begin
               wake_ev = 1'b1;
               st_next = WIPC_ACTIVE;
            end else begin
               st_next = WIPC_LOWPWR;
            end
         end
         default: begin
            st_next = WIPC_START;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // interrupt line control
   // ---------------------------------------------------------------
   logic               flag_reg;              // irq_flag_bit
   logic               flag_next;
   logic               hold_reg;              // held-low drive
   logic               hold_next;
   logic [PULSE_W-1:0] pulse_reg;             // remaining pulse cycles
   logic [PULSE_W-1:0] pulse_next;
   logic [CLR_W-1:0]   clr_reg;               // release countdown, 0 idle
   logic [CLR_W-1:0]   clr_next;
   wipc_status_s       stat_reg;
   wipc_status_s       stat_next;
   logic               irq_event;
   logic               tl_fault_reg;          // thermal_limit_fault
   logic               tl_fault_next;
   logic               mode_reg;              // 1 selects pulsed style
   logic               mode_next;

   always_comb begin
      // any cause of an interrupt
      irq_event  = act_change | timer_ev | wake_ev | (fault_event & st_reg == WIPC_ACTIVE)
                 | (tl_fault_next & ~tl_fault_reg);
      mode_next  = irq_pulse_mode;
      flag_next  = flag_reg;
      hold_next  = hold_reg;
      pulse_next = (pulse_reg != '0) ? pulse_reg - PULSE_W'(1) : pulse_reg;
      clr_next   = (clr_reg != '0) ? clr_reg - CLR_W'(1) : clr_reg;
      stat_next  = stat_reg;
      if (cs_fall) begin
         stat_next.irq_line_level = irq_s;
         stat_next.irq_flag_bit   = flag_reg;
         clr_next                 = CLR_W'(CLR_CYC);
      end
      if (clr_reg == CLR_W'(1)) begin
         flag_next = 1'b0;
         hold_next = 1'b0;
      end
      if (irq_request) begin
         pulse_next = PULSE_LEN;
      end
      // a new event cancels any pending release, so a change seen while select is low survives
      if (irq_event) begin
         flag_next = 1'b1;
         clr_next  = '0;                      // stale release must not clear it
         if (mode_reg) begin
            pulse_next = PULSE_LEN;
         end else begin
            hold_next = 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // thermal handling
   // ---------------------------------------------------------------
   always_comb begin
      tl_fault_next = tl_fault_reg;
      if (|thermal_limit_cells) begin
         tl_fault_next = 1'b1;
      end else if (thermal_below_hys) begin
         tl_fault_next = 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_reg       <= WIPC_START;
         prev_reg     <= 3'h7;
         ref_reg      <= '0;
         poll_cnt_reg <= '0;
         itmr_cnt_reg <= '0;
         bypass_reg   <= 1'b0;
         flag_reg     <= 1'b0;
         hold_reg     <= 1'b0;
         pulse_reg    <= '0;
         clr_reg      <= '0;
         stat_reg     <= '0;
         tl_fault_reg <= 1'b0;
         mode_reg     <= RST_PULSE_MODE;
      end else begin
         st_reg       <= st_next;
         prev_reg     <= prev_next;
         ref_reg      <= ref_next;
         poll_cnt_reg <= poll_cnt_next;
         itmr_cnt_reg <= itmr_cnt_next;
         bypass_reg   <= bypass_next;
         flag_reg     <= flag_next;
         hold_reg     <= hold_next;
         pulse_reg    <= pulse_next;
         clr_reg      <= clr_next;
         stat_reg     <= stat_next;
         tl_fault_reg <= tl_fault_next;
         mode_reg     <= mode_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign low_power_state      = (st_reg == WIPC_LOWPWR) || (st_reg == WIPC_CHECK);
   assign fast_osc_en          = (st_reg == WIPC_ACTIVE);
   assign wake_pin_o           = 1'b0;
   assign wake_pin_oe          = ~low_power_state;
   assign irq_pin_o            = 1'b0;
   assign irq_pin_oe           = hold_reg | (pulse_reg != '0)
                               | (st_reg == WIPC_START);
   assign status               = stat_reg;
   assign switch_closed        = ref_reg;
   assign poll_strobe          = poll_go;
   assign wake_event           = wake_ev;
   assign thermal_limit_fault  = tl_fault_reg;
   assign wetting_limit        = tl_fault_reg;
   assign thermal_warning_flag = thermal_warn_in;

endmodule // wipc_ctrl

// ---- verif/wipc_ctrl_monitor.sv ----
// concurrent checks on the pin controller ports
`timescale 1ns/1ps

module wipc_ctrl_monitor (
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic       wake_pin_o,
   input wire logic       wake_pin_oe,
   input wire logic       irq_pin_o,
   input wire logic       irq_pin_oe,
   input wire logic       irq_request,
   input wire logic       ready,
   input wire logic [3:0] thermal_limit_cells,
   input wire logic       thermal_warn_in,
   input wire logic       low_power_state,
   input wire logic       fast_osc_en,
   input wire logic       wake_event,
   input wire logic       thermal_limit_fault,
   input wire logic       wetting_limit,
   input wire logic       thermal_warning_flag
);
   // one domain, so one clock and one reset for all
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   a_wake_drive_state: assert property (wake_pin_oe == !low_power_state)
      else $error("wake pin drive does not follow state");
   a_fast_osc_active: assert property (fast_osc_en |-> !low_power_state)
      else $error("fast oscillator on in low power");
   a_pins_open_drain: assert property (!irq_pin_o && !wake_pin_o)
      else $error("pin drives a high level");
   a_startup_irq_hold: assert property (!ready && !fast_osc_en && !low_power_state
      |-> irq_pin_oe)
      else $error("line released before ready");
   a_request_pulse_low: assert property (irq_request && fast_osc_en
      |-> ##[1:2] irq_pin_oe [*8])
      else $error("request pulse missing or short");
   a_wake_leaves_lp: assert property (wake_event |-> ##[0:1] (wake_pin_oe && fast_osc_en))
      else $error("wake event without return to active");
   a_wake_raises_irq: assert property (wake_event |-> ##[0:2] irq_pin_oe)
      else $error("wake event without interrupt");
   a_thermal_or_fault: assert property ($rose(|thermal_limit_cells) && fast_osc_en
      |-> ##[1:4] (thermal_limit_fault && wetting_limit))
      else $error("thermal cell not reported as fault");
   a_warn_flag_pass: assert property (thermal_warning_flag == thermal_warn_in)
      else $error("warning flag differs from sensor");

   // main scenarios reached
   c_wake: cover property (wake_event);
   c_req: cover property (irq_request && fast_osc_en);
   c_therm: cover property ($rose(thermal_limit_fault));
endmodule // wipc_ctrl_monitor

bind wipc_ctrl wipc_ctrl_monitor u_mon (.clk(clk), .resetn(resetn), .wake_pin_o(wake_pin_o),
   .wake_pin_oe(wake_pin_oe), .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe),
   .irq_request(irq_request), .ready(ready), .thermal_limit_cells(thermal_limit_cells),
   .thermal_warn_in(thermal_warn_in), .low_power_state(low_power_state),
   .fast_osc_en(fast_osc_en), .wake_event(wake_event),
   .thermal_limit_fault(thermal_limit_fault), .wetting_limit(wetting_limit),
   .thermal_warning_flag(thermal_warning_flag));

// ---- verif/wipc_host_model.sv ----
// host side of the two open-drain lines, with pull-ups
`timescale 1ns/1ps

module wipc_host_model (
   input wire logic irq_oe,      // device pulls shared line
   input wire logic wake_oe,     // device pulls wake line
   input wire logic irq_pull,    // another wired device pulls
   input wire logic wake_pull,   // host or switch pulls wake
   output logic irq_line,  // resolved shared line
   output logic wake_line  // resolved wake line
);
   // any puller wins, else the pull-up lifts the line
   assign irq_line  = !(irq_oe || irq_pull);
   assign wake_line = !(wake_oe || wake_pull);
endmodule // wipc_host_model

// ---- verif/test_wake_and_interrupt_pin_control.sv ----
// self-checking bench for the pin controller
`timescale 1ns/1ps

module test_wake_and_interrupt_pin_control;
   import wipc_pkg::*;
   localparam int PL = 20;                    // shortened pulse length
   logic clk = 0, resetn = 0, cs_n = 1, vio = 1, scc = 0, req = 0, elp = 0, rdy = 0;
   logic hys = 0, warn = 0, oirq = 0, owake = 0, pm = 0, flt = 0;
   logic [3:0] tcell = 4'h0;
   logic [NCH-1:0] cmp = '1, bsc = 33'h2, ien = '0, sw;
   wipc_timer_cfg_s tcfg = '{16'hffff, 16'hffff};
   wipc_status_s st;
   logic wk_i, wk_oe, iq_i, iq_oe, lp, fo, wev, tf, wl, tw;
   int miscompares = 0, checked = 0, cyc = 0;

   always #4 clk = ~clk;                      // 125 mhz

   wipc_host_model host (.irq_oe(iq_oe), .wake_oe(wk_oe), .irq_pull(oirq),
      .wake_pull(owake), .irq_line(iq_i), .wake_line(wk_i));

   wipc_ctrl #(.PULSE_LEN(16'(PL))) dut (.clk(clk), .resetn(resetn),
      .wake_pin_i(wk_i), .wake_pin_o(), .wake_pin_oe(wk_oe), .irq_pin_i(iq_i),
      .irq_pin_o(), .irq_pin_oe(iq_oe), .cs_n_i(cs_n), .io_supply(vio), .cmp_above(cmp),
      .battery_switch_config(bsc), .irq_enable(ien), .wake_enable('0),
      .analog_output_mux_sel_valid(1'b0), .analog_output_mux_sel(6'h00), .supply_check_cfg(scc),
      .irq_pulse_mode(pm), .irq_request(req), .enter_low_power(elp), .ready(rdy),
      .fault_event(flt), .thermal_limit_cells(tcell), .thermal_below_hys(hys),
      .thermal_warn_in(warn), .timer_cfg(tcfg), .status(st), .switch_closed(sw),
      .low_power_state(lp), .fast_osc_en(fo), .poll_strobe(), .wake_event(wev),
      .thermal_limit_fault(tf), .wetting_limit(wl), .thermal_warning_flag(tw));

   task automatic end_sim;
      if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         miscompares++;
         end_sim();
      end
   end

   task automatic chk(string n, logic [1:0] e, logic [1:0] s);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic w(int n); repeat (n) @(negedge clk); endtask

   // select low long enough for the delayed release
   task automatic cs_clear;
      cs_n = 0; w(140); cs_n = 1; w(5);
   endtask
   task automatic go_lp;
      elp = 1; w(1); elp = 0; w(6);
   endtask
   // watch a bounded span for the one-cycle wake pulse
   task automatic wait_wake(logic e);
      logic seen = 0;
      repeat (12) begin
         w(1);
         seen |= wev;
      end
      chk("wake_event", e, seen);
   endtask

   task automatic t_start;
      w(5); chk("irq_oe", 1, iq_oe); chk("wake_oe", 1, wk_oe);
      rdy = 1; w(4); chk("fast_osc", 1, fo); chk("irq_oe", 0, iq_oe);
      chk("closed1", 1, sw[1]); chk("closed0", 0, sw[0]);
   endtask
   task automatic t_change;
      ien[0] = 1; cmp[0] = 0; w(6);
      chk("closed0", 1, sw[0]); chk("irq_oe", 1, iq_oe);
      cs_n = 0; w(6); chk("status", 2'b01, st); chk("irq_oe", 1, iq_oe);
      w(118); chk("irq_oe", 1, iq_oe); w(8); chk("irq_oe", 0, iq_oe); cs_n = 1; w(5);
      cs_n = 0; w(6); chk("status", 2'b10, st); cs_n = 1; w(5);
      cs_n = 0; w(20); cmp[0] = 1; w(200); cs_n = 1; w(5);
      chk("irq_oe", 1, iq_oe); cs_clear();
   endtask
   // the pulse starts at the edge that takes the request, so count from that cycle
   task automatic t_pulse;
      int n = 0;
      int m = 0;
      req = 1; w(1); req = 0;
      repeat (60) begin
         n += iq_oe;
         w(1);
      end
      chk("pulse_len", 1, n == PL);
      pm = 1; w(2); cmp[0] = 0;
      repeat (60) begin
         m += iq_oe;
         w(1);
      end
      chk("pulse_style", 1, m == PL);
      pm = 0; cmp[0] = 1; w(6); chk("irq_oe", 1, iq_oe); cs_clear();
   endtask
   task automatic t_wake;
      go_lp(); chk("lp", 1, lp); chk("wake_oe", 0, wk_oe); chk("fast", 0, fo);
      owake = 1; wait_wake(1);
      chk("wake_oe", 1, wk_oe); chk("irq_oe", 1, iq_oe); owake = 0; cs_clear();
      vio = 0; go_lp(); owake = 1; wait_wake(0); chk("lp", 1, lp);
      owake = 0; w(6); scc = 1; owake = 1; wait_wake(1);
      owake = 0; vio = 1; cs_clear(); go_lp(); oirq = 1; wait_wake(1);
      oirq = 0; cs_clear();
   endtask
   task automatic t_therm;
      tcell = 4'h4; w(6); chk("fault", 1, tf); chk("wetting", 1, wl);
      chk("fault_irq", 1, iq_oe);
      warn = 1; w(2); chk("warn", 1, tw); tcell = 0; w(6); chk("fault", 1, tf);
      hys = 1; w(6); chk("fault", 0, tf);
      cs_clear(); chk("irq_oe", 0, iq_oe);
      flt = 1; w(1); flt = 0; w(3); chk("fault_irq", 1, iq_oe);
   endtask

   initial begin
      w(12);
      resetn = 1;
      t_start();
      t_change();
      t_pulse();
      t_wake();
      t_therm();
      end_sim();
   end
endmodule // test_wake_and_interrupt_pin_control
